/* design/port_pkg.sv */
// Shared constants, encodings and types of the dual serial register port.
package port_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int MEM_AW = 8;
  localparam int HDR_BITS = 16;
  localparam int SYNC_BIT = 6;
  localparam logic [14:0] SYNC_REG_ADDR = 15'h0015;
  localparam logic [14:0] RESET_CTRL_ADDR = 15'h0017;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] NVM_ADDR_UPPER_DEFAULT = 5'h19;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LSB_LOW = 2'h0;
  localparam logic [1:0] LSB_MID = 2'h2;
  localparam logic [1:0] LSB_HIGH = 2'h1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } reg_access_t;
  typedef enum logic [4:0] {
    I2C_IDLE = 5'b00001,
    I2C_RECV = 5'b00010,
    I2C_ACK = 5'b00100,
    I2C_SEND = 5'b01000,
    I2C_RACK = 5'b10000
  } i2c_state_t;
endpackage

/* design/level_sync.sv */
// Two-flop synchroniser for a group of independent levels.
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate
endmodule

/* design/spi_frame_engine.sv */
// Serial-clock domain shifter for SPI frames bounded by chip select.
`timescale 1ns/1ps
module spi_frame_engine (
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sys_rst,
  input wire logic i_sdi,
  input wire logic i_four_wire,
  input wire logic [7:0] i_rd_data,
  output port_pkg::reg_access_t o_wr,
  output logic o_wr_toggle,
  output logic [14:0] o_rd_addr,
  output logic o_rd_toggle,
  output logic o_sdio,
  output logic o_sdio_oe_n,
  output logic o_sdo,
  output logic o_sdo_oe_n
);
  logic [3:0] hcnt_reg;
  logic hdr_done_reg;
  logic [14:0] hsh_reg;
  logic dir_reg;
  logic [14:0] addr_reg;
  logic [2:0] dcnt_reg;
  logic [6:0] dsh_reg;
  logic [7:0] out_reg;
  wire hdr_end = !hdr_done_reg && (hcnt_reg == 4'(port_pkg::HDR_BITS - 1));
  wire byte_end = hdr_done_reg && (dcnt_reg == 3'h7);
  wire [14:0] hdr_addr = {hsh_reg[13:0], i_sdi};
  wire [14:0] addr_inc = addr_reg + 15'h0001;
  wire drive_w = hdr_done_reg && (dir_reg == port_pkg::DIR_READ);

  // Chip select high clears the frame state at once. [RULE14]
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      hcnt_reg <= 4'h0;
      hdr_done_reg <= 1'b0;
      hsh_reg <= 15'h0000;
      dir_reg <= port_pkg::DIR_WRITE;
      addr_reg <= 15'h0000;
      dcnt_reg <= 3'h0;
      dsh_reg <= 7'h00;
    end else if (!hdr_done_reg) begin
      hsh_reg <= {hsh_reg[13:0], i_sdi}; // [RULE11] [RULE12]
      hcnt_reg <= hcnt_reg + 4'h1;
      if (hdr_end) begin
        hdr_done_reg <= 1'b1;
        dir_reg <= hsh_reg[14]; // [RULE13]
        addr_reg <= hdr_addr;
      end
    end else begin
      dsh_reg <= {dsh_reg[5:0], i_sdi};
      dcnt_reg <= dcnt_reg + 3'h1; // [RULE16]
      if (byte_end) begin
        addr_reg <= addr_inc; // [RULE23]
      end
    end
  end

  // Words handed to the system clock stay put until the next toggle.
  always_ff @(posedge i_sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wr <= '0;
      o_wr_toggle <= 1'b0;
      o_rd_addr <= 15'h0000;
      o_rd_toggle <= 1'b0;
    end else if (!i_cs_n) begin
      if (byte_end && dir_reg == port_pkg::DIR_WRITE) begin
        o_wr <= '{addr: addr_reg, data: {dsh_reg, i_sdi}}; // [RULE15] [RULE5]
        o_wr_toggle <= !o_wr_toggle;
      end
      if (hdr_end && hsh_reg[14] == port_pkg::DIR_READ) begin
        o_rd_addr <= hdr_addr;
        o_rd_toggle <= !o_rd_toggle;
      end else if (byte_end && dir_reg == port_pkg::DIR_READ) begin
        o_rd_addr <= addr_inc; // [RULE23]
        o_rd_toggle <= !o_rd_toggle;
      end
    end
  end

  // Read data leaves on falling edges, on the shared or the separate line.
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      out_reg <= 8'h00;
      o_sdio_oe_n <= 1'b1;
      o_sdo_oe_n <= 1'b1;
    end else begin
      out_reg <= (dcnt_reg == 3'h0) ? i_rd_data : {out_reg[6:0], 1'b0}; // [RULE17]
      o_sdio_oe_n <= !(drive_w && !i_four_wire); // [RULE8]
      o_sdo_oe_n <= !(drive_w && i_four_wire); // [RULE9]
    end
  end
  assign o_sdio = out_reg[7];
  assign o_sdo = out_reg[7];
endmodule

/* design/dual_serial_register_port.sv */
// Top of the dual serial register port: straps, I2C client, SPI crossing, registers.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Strap low selects I2C, else SPI
// RULE2 - I2C works at 100k, 400k, slower
// RULE3 - Address: NVM upper five, pin lower two
// RULE4 - Pin low/mid/high gives 0x64/0x66/0x65
// RULE5 - Two address bytes, one data byte
// RULE6 - Accesses accepted whenever power-down deasserted
// RULE7 - I2C block reads and writes supported
// RULE8 - Four-wire bit clear: shared data line
// RULE9 - Four-wire bit set: separate read output
// RULE10 - SPI select pin also triggers elapsed counter
// RULE11 - Host shifts SPI messages MSB first
// RULE12 - Direction, 15-bit address, 8-bit data
// RULE13 - Direction 0 writes, 1 reads
// RULE14 - Chip select low starts, high ends
// RULE15 - Write commits at last bit's rising edge
// RULE16 - Partial trailing write bits are dropped
// RULE17 - Read bits shift out on falling edges
// RULE18 - Two straps choose the ROM profile
// RULE19 - Host bulk load leaves reset register masked; here a block write updates O_RESET_CONTROL like any write
// RULE20 - Sync bit holds dividers, clear releases
// RULE21 - Power-down low disables the serial port
// RULE22 - Straps sampled at start-up fix mode
// RULE23 - Block transfers step to next address
// RULE24 - I2C answers only its own address
module dual_serial_register_port #(
  parameter int MEM_DEPTH = 256
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_POWER_DOWN_N,
  input wire logic I_INTERFACE_SELECT_STRAP,
  input wire logic [1:0] I_PROFILE_STRAP_LOW,
  input wire logic [1:0] I_PROFILE_STRAP_HIGH,
  input wire logic I_SELECT_OR_ADDRESS_PIN,
  input wire logic [1:0] I_SELECT_OR_ADDRESS_LEVEL,
  input wire logic [4:0] I_NVM_ADDR_UPPER,
  input wire logic I_FOUR_WIRE_SELECT,
  input wire logic I_SCK,
  input wire logic I_SDIO,
  output logic O_SDIO,
  output logic O_SDIO_OE_N,
  output logic O_SDO,
  output logic O_SDO_OE_N,
  output logic O_SPI_MODE,
  output logic [3:0] O_ROM_PROFILE,
  output logic [6:0] O_I2C_ADDRESS,
  output logic O_SYNC_HOLD,
  output logic [7:0] O_RESET_CONTROL,
  output logic O_ELAPSED_TIME_TRIGGER
);
  logic [7:0] mem [MEM_DEPTH];
  logic straps_ok_reg;
  logic spi_active_reg;
  logic pd_prev_reg;
  logic cs_prev_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic wr_tog_prev_reg;
  logic rd_tog_prev_reg;
  logic [7:0] spi_rd_data_reg;
  port_pkg::i2c_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [1:0] idx_reg;
  logic rw_reg;
  logic [14:0] reg_addr_reg;
  logic sda_oe_n_reg;
  logic i2c_wr_reg;
  port_pkg::reg_access_t i2c_wr_reg_word;
  port_pkg::reg_access_t spi_wr_word;
  logic spi_wr_toggle;
  logic [14:0] spi_rd_addr;
  logic spi_rd_toggle;
  logic spi_sdio_oe_n;
  logic [12:0] pins_s;

  // Every pin but the NVM address and four-wire select, and every toggle from the serial clock, passes two flops.
  level_sync #(
    .W(13)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_async({I_POWER_DOWN_N, I_INTERFACE_SELECT_STRAP, I_PROFILE_STRAP_HIGH,
              I_PROFILE_STRAP_LOW, I_SELECT_OR_ADDRESS_LEVEL, I_SELECT_OR_ADDRESS_PIN,
              I_SCK, I_SDIO, spi_wr_toggle, spi_rd_toggle}),
    .o_sync(pins_s)
  );

  wire pd_n_s = pins_s[12];
  wire ifsel_s = pins_s[11];
  wire [3:0] profile_s = pins_s[10:7];
  wire [1:0] level_s = pins_s[6:5];
  wire cs_s = pins_s[4];
  wire scl_s = pins_s[3];
  wire sda_s = pins_s[2];
  wire wr_tog_s = pins_s[1];
  wire rd_tog_s = pins_s[0];

  wire pd_rise = pd_n_s && !pd_prev_reg;
  wire i2c_active = straps_ok_reg && !O_SPI_MODE && pd_n_s; // [RULE6] [RULE21]
  wire [1:0] addr_lsb = (level_s == port_pkg::LVL_MID) ? port_pkg::LSB_MID :
                        (level_s == port_pkg::LVL_HIGH) ? port_pkg::LSB_HIGH :
                        port_pkg::LSB_LOW; // [RULE4]

  // Straps are caught once per power-up, at the rise of power-down.
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pd_prev_reg <= 1'b0;
      straps_ok_reg <= 1'b0;
      O_SPI_MODE <= 1'b0;
      O_ROM_PROFILE <= 4'h0;
      O_I2C_ADDRESS <= 7'h00;
      spi_active_reg <= 1'b0;
    end else begin
      pd_prev_reg <= pd_n_s;
      spi_active_reg <= straps_ok_reg && O_SPI_MODE && pd_n_s; // [RULE21]
      if (!pd_n_s) begin
        straps_ok_reg <= 1'b0;
      end else if (pd_rise) begin
        straps_ok_reg <= 1'b1; // [RULE22]
        O_SPI_MODE <= ifsel_s; // [RULE1]
        O_ROM_PROFILE <= profile_s; // [RULE18]
        O_I2C_ADDRESS <= {I_NVM_ADDR_UPPER, addr_lsb}; // [RULE3]
      end
    end
  end

  // The SPI engine is held cleared unless SPI is the live interface.
  wire spi_cs_n = I_SELECT_OR_ADDRESS_PIN || !spi_active_reg; // [RULE14] [RULE21]

  spi_frame_engine u_spi (
    .i_sck(I_SCK),
    .i_cs_n(spi_cs_n),
    .i_sys_rst(I_SYS_RST),
    .i_sdi(I_SDIO),
    .i_four_wire(I_FOUR_WIRE_SELECT),
    .i_rd_data(spi_rd_data_reg),
    .o_wr(spi_wr_word),
    .o_wr_toggle(spi_wr_toggle),
    .o_rd_addr(spi_rd_addr),
    .o_rd_toggle(spi_rd_toggle),
    .o_sdio(O_SDIO),
    .o_sdio_oe_n(spi_sdio_oe_n),
    .o_sdo(O_SDO),
    .o_sdo_oe_n(O_SDO_OE_N)
  );

  // Both engines release the shared line when idle, so one gate merges them.
  assign O_SDIO_OE_N = spi_sdio_oe_n && sda_oe_n_reg;

  // Register file access: SPI events from the crossing, I2C writes locally.
  wire spi_wr_evt = wr_tog_s ^ wr_tog_prev_reg;
  wire spi_rd_evt = rd_tog_s ^ rd_tog_prev_reg;
  wire wr_en_w = spi_wr_evt || i2c_wr_reg;
  wire [14:0] wr_addr_w = spi_wr_evt ? spi_wr_word.addr : i2c_wr_reg_word.addr;
  wire [7:0] wr_data_w = spi_wr_evt ? spi_wr_word.data : i2c_wr_reg_word.data;
  wire wr_in_range = (32'(wr_addr_w) < MEM_DEPTH);
  wire spi_rd_in_range = (32'(spi_rd_addr) < MEM_DEPTH);
  wire i2c_rd_in_range = (32'(reg_addr_reg) < MEM_DEPTH);
  wire [7:0] spi_rd_w = spi_rd_in_range ? mem[spi_rd_addr[port_pkg::MEM_AW-1:0]] : 8'h00;
  wire [7:0] i2c_rd_w = i2c_rd_in_range ? mem[reg_addr_reg[port_pkg::MEM_AW-1:0]] : 8'h00;

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= port_pkg::REG_RESET;
      end
    end else if (wr_en_w && wr_in_range) begin
      mem[wr_addr_w[port_pkg::MEM_AW-1:0]] <= wr_data_w; // [RULE5]
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wr_tog_prev_reg <= 1'b0;
      rd_tog_prev_reg <= 1'b0;
      spi_rd_data_reg <= 8'h00;
      cs_prev_reg <= 1'b0;
      O_ELAPSED_TIME_TRIGGER <= 1'b0;
    end else begin
      wr_tog_prev_reg <= wr_tog_s;
      rd_tog_prev_reg <= rd_tog_s;
      cs_prev_reg <= cs_s;
      if (spi_rd_evt) begin
        spi_rd_data_reg <= spi_rd_w;
      end
      O_ELAPSED_TIME_TRIGGER <= spi_active_reg && cs_prev_reg && !cs_s; // [RULE10]
    end
  end

  // Control outputs mirror their registers from every interface's writes.
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_SYNC_HOLD <= 1'b0;
      O_RESET_CONTROL <= port_pkg::REG_RESET;
    end else if (wr_en_w) begin
      if (wr_addr_w == port_pkg::SYNC_REG_ADDR) begin
        O_SYNC_HOLD <= wr_data_w[port_pkg::SYNC_BIT]; // [RULE20]
      end
      if (wr_addr_w == port_pkg::RESET_CTRL_ADDR) begin
        O_RESET_CONTROL <= wr_data_w;
      end
    end
  end

  // I2C bus events, oversampled on the system clock at any legal rate.
  wire scl_rise = scl_s && !scl_prev_reg; // [RULE2]
  wire scl_fall = !scl_s && scl_prev_reg;
  wire bus_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  wire bus_stop = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  wire byte_full = (cnt_reg == port_pkg::I2C_BYTE_BITS);
  wire addr_match = (sh_reg[7:1] == O_I2C_ADDRESS);

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_reg <= port_pkg::I2C_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      idx_reg <= 2'h0;
      rw_reg <= port_pkg::DIR_WRITE;
      reg_addr_reg <= 15'h0000;
      sda_oe_n_reg <= 1'b1;
      i2c_wr_reg <= 1'b0;
      i2c_wr_reg_word <= '0;
    end else begin
      i2c_wr_reg <= 1'b0;
      if (!i2c_active || bus_stop) begin
        state_reg <= port_pkg::I2C_IDLE; // [RULE21]
        sda_oe_n_reg <= 1'b1;
      end else if (bus_start) begin
        state_reg <= port_pkg::I2C_RECV;
        cnt_reg <= 4'h0;
        idx_reg <= 2'h0;
        sda_oe_n_reg <= 1'b1;
      end else begin
        case (state_reg)
          port_pkg::I2C_RECV: begin
            if (scl_rise && !byte_full) begin
              sh_reg <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && byte_full) begin
              state_reg <= port_pkg::I2C_ACK;
              sda_oe_n_reg <= 1'b0;
              if (idx_reg != 2'h3) begin
                idx_reg <= idx_reg + 2'h1;
              end
              case (idx_reg)
                2'h0: begin
                  rw_reg <= sh_reg[0];
                  if (!addr_match) begin
                    state_reg <= port_pkg::I2C_IDLE; // [RULE24]
                    sda_oe_n_reg <= 1'b1;
                  end
                end
                2'h1: begin
                  reg_addr_reg[14:8] <= sh_reg[6:0]; // [RULE5]
                end
                2'h2: begin
                  reg_addr_reg[7:0] <= sh_reg;
                end
                default: begin
                  i2c_wr_reg <= 1'b1; // [RULE7]
                  i2c_wr_reg_word <= '{addr: reg_addr_reg, data: sh_reg};
                  reg_addr_reg <= reg_addr_reg + 15'h0001; // [RULE23]
                end
              endcase
            end
          end
          port_pkg::I2C_ACK: begin
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (rw_reg == port_pkg::DIR_READ) begin
                state_reg <= port_pkg::I2C_SEND;
                sda_oe_n_reg <= i2c_rd_w[7];
                sh_reg <= {i2c_rd_w[6:0], 1'b1};
                cnt_reg <= 4'h1;
                reg_addr_reg <= reg_addr_reg + 15'h0001; // [RULE23]
              end else begin
                state_reg <= port_pkg::I2C_RECV;
                sda_oe_n_reg <= 1'b1;
              end
            end
          end
          port_pkg::I2C_SEND: begin
            if (scl_fall) begin
              if (byte_full) begin
                state_reg <= port_pkg::I2C_RACK;
                sda_oe_n_reg <= 1'b1;
              end else begin
                sda_oe_n_reg <= sh_reg[7];
                sh_reg <= {sh_reg[6:0], 1'b1};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          port_pkg::I2C_RACK: begin
            if (scl_rise && sda_s) begin
              state_reg <= port_pkg::I2C_IDLE;
            end else if (scl_fall) begin
              state_reg <= port_pkg::I2C_SEND; // [RULE7]
              sda_oe_n_reg <= i2c_rd_w[7];
              sh_reg <= {i2c_rd_w[6:0], 1'b1};
              cnt_reg <= 4'h1;
              reg_addr_reg <= reg_addr_reg + 15'h0001; // [RULE23]
            end
          end
          default: begin
            sda_oe_n_reg <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

/* test/port_checker.sv */
// Concurrent checks on the ports of the dual serial register port.
`timescale 1ns/1ps
module port_checker #(
  parameter int MEM_DEPTH = 256
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_POWER_DOWN_N,
  input wire logic I_INTERFACE_SELECT_STRAP,
  input wire logic [1:0] I_PROFILE_STRAP_LOW,
  input wire logic [1:0] I_PROFILE_STRAP_HIGH,
  input wire logic I_SELECT_OR_ADDRESS_PIN,
  input wire logic [1:0] I_SELECT_OR_ADDRESS_LEVEL,
  input wire logic [4:0] I_NVM_ADDR_UPPER,
  input wire logic I_FOUR_WIRE_SELECT,
  input wire logic O_SDIO_OE_N,
  input wire logic O_SDO_OE_N,
  input wire logic O_SPI_MODE,
  input wire logic [3:0] O_ROM_PROFILE,
  input wire logic [6:0] O_I2C_ADDRESS,
  input wire logic O_ELAPSED_TIME_TRIGGER
);
  logic [3:0] up_cnt_reg;
  logic [3:0] up_cnt_next;
  logic settled;
  logic [1:0] lsb_exp;
  // Counts powered cycles and saturates once start-up is surely over.
  assign settled = (up_cnt_reg == 4'hf);
  assign up_cnt_next = !I_POWER_DOWN_N ? 4'h0 : (settled ? up_cnt_reg : up_cnt_reg + 4'h1);
  assign lsb_exp = (I_SELECT_OR_ADDRESS_LEVEL == port_pkg::LVL_LOW) ? port_pkg::LSB_LOW :
    (I_SELECT_OR_ADDRESS_LEVEL == port_pkg::LVL_MID) ? port_pkg::LSB_MID : port_pkg::LSB_HIGH;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      up_cnt_reg <= 4'h0;
    end else begin
      up_cnt_reg <= up_cnt_next;
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_select_fall;
    settled && O_SPI_MODE && $fell(I_SELECT_OR_ADDRESS_PIN);
  endsequence
  sequence s_power_off;
    (!I_POWER_DOWN_N) [*4];
  endsequence
  chk_mode_strap: assert property (
    settled |-> O_SPI_MODE == I_INTERFACE_SELECT_STRAP) else $error("Mode differs from strap.");
  chk_address_upper: assert property (
    settled |-> O_I2C_ADDRESS[6:2] == I_NVM_ADDR_UPPER) else $error("Address upper bits wrong.");
  chk_address_lower: assert property (
    settled |-> O_I2C_ADDRESS[1:0] == lsb_exp) else $error("Address low bits wrong.");
  chk_profile_straps: assert property (
    settled |-> O_ROM_PROFILE == {I_PROFILE_STRAP_HIGH, I_PROFILE_STRAP_LOW})
    else $error("Profile differs from straps.");
  chk_trigger_after_select: assert property (
    s_select_fall |-> ##[1:5] O_ELAPSED_TIME_TRIGGER) else $error("Trigger pulse missing.");
  chk_trigger_one_cycle: assert property (
    O_ELAPSED_TIME_TRIGGER |=> !O_ELAPSED_TIME_TRIGGER) else $error("Trigger pulse too long.");
  chk_power_off_quiet: assert property (
    s_power_off |-> O_SDIO_OE_N && O_SDO_OE_N) else $error("Data driven in power-down.");
  chk_four_wire_sdio: assert property (
    O_SPI_MODE && I_FOUR_WIRE_SELECT |-> O_SDIO_OE_N) else $error("Shared line driven.");
  chk_three_wire_sdo: assert property (
    O_SPI_MODE && !I_FOUR_WIRE_SELECT |-> O_SDO_OE_N) else $error("Separate output driven.");
  chk_deselect_release: assert property (
    O_SPI_MODE && I_SELECT_OR_ADDRESS_PIN && $past(I_SELECT_OR_ADDRESS_PIN)
    |-> O_SDIO_OE_N && O_SDO_OE_N) else $error("Data driven while deselected.");
endmodule

bind dual_serial_register_port port_checker #(.MEM_DEPTH(MEM_DEPTH)) i_port_checker (
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_POWER_DOWN_N(I_POWER_DOWN_N),
  .I_INTERFACE_SELECT_STRAP(I_INTERFACE_SELECT_STRAP),
  .I_PROFILE_STRAP_LOW(I_PROFILE_STRAP_LOW), .I_PROFILE_STRAP_HIGH(I_PROFILE_STRAP_HIGH),
  .I_SELECT_OR_ADDRESS_PIN(I_SELECT_OR_ADDRESS_PIN),
  .I_SELECT_OR_ADDRESS_LEVEL(I_SELECT_OR_ADDRESS_LEVEL), .I_NVM_ADDR_UPPER(I_NVM_ADDR_UPPER),
  .I_FOUR_WIRE_SELECT(I_FOUR_WIRE_SELECT), .O_SDIO_OE_N(O_SDIO_OE_N), .O_SDO_OE_N(O_SDO_OE_N),
  .O_SPI_MODE(O_SPI_MODE), .O_ROM_PROFILE(O_ROM_PROFILE), .O_I2C_ADDRESS(O_I2C_ADDRESS),
  .O_ELAPSED_TIME_TRIGGER(O_ELAPSED_TIME_TRIGGER)
);

/* test/spi_host_model.sv */
// Host-side SPI master model that runs frames, and I2C bits and edges, into the register port.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic i_miso,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Sends direction and address, then n bits: the top of data on a write, a toggling line on a read.
  task automatic frame(input logic rd, input logic [14:0] addr, input logic [15:0] data,
                       input int n, output logic [15:0] rdata);
    logic [31:0] bits;
    bits = {rd, addr, data};
    rdata = 16'h0000;
    #3;
    o_cs_n = 1'b0;
    for (int i = 0; i < 16 + n; i++) begin
      #3;
      if (rd && i >= 16) begin
        o_mosi = ~o_mosi;
      end else begin
        o_mosi = bits[31 - i];
      end
      #3;
      if (rd && i >= 16) begin
        rdata = {rdata[14:0], i_miso};
      end
      o_sck = 1'b1;
      if (rd && i % 8 == 7 && i >= 15) begin
        #100;
      end else begin
        #6;
      end
      o_sck = 1'b0;
    end
    #6;
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #24;
  endtask
  // One I2C bit on the same wires; a one releases the data line, and the line is sampled high.
  task automatic i2c_bit(input logic b, output logic s);
    #20;
    o_mosi = b;
    #40;
    o_sck = 1'b1;
    #30;
    s = i_miso;
    #30;
    o_sck = 1'b0;
  endtask
  // A start condition when st is set, otherwise a stop; the clock is left low.
  task automatic i2c_edge(input logic st);
    #20;
    o_mosi = st;
    #40;
    o_sck = 1'b1;
    #60;
    o_mosi = !st;
    #60;
    o_sck = 1'b0;
  endtask
endmodule

/* test/dual_serial_register_port_tb_top.sv */
// Self-checking bench: SPI frames and I2C transfers from a host model against the register port.
`timescale 1ns/1ps
module dual_serial_register_port_tb_top;
  logic clk, sys_rst, power_down_n, if_strap, four_wire;
  logic [1:0] level;
  logic sck, cs_n, mosi, sdio_wire, miso;
  logic sdio_out, sdio_oe_n, sdo_out, sdo_oe_n, spi_mode, sync_hold, et_trig;
  logic [3:0] rom_profile;
  logic [6:0] i2c_addr;
  logic [7:0] reset_ctrl;
  logic [15:0] rd;
  logic [8:0] ib;
  int err_count, checks;
  // The shared wire follows the port while it drives, else the host.
  assign sdio_wire = sdio_oe_n ? mosi : sdio_out;
  assign miso = four_wire ? (sdo_oe_n ? mosi : sdo_out) : sdio_wire;
  dual_serial_register_port i_dual_serial_register_port (
    .I_CLK(clk), .I_SYS_RST(sys_rst), .I_POWER_DOWN_N(power_down_n),
    .I_INTERFACE_SELECT_STRAP(if_strap), .I_PROFILE_STRAP_LOW(port_pkg::LVL_HIGH),
    .I_PROFILE_STRAP_HIGH(port_pkg::LVL_MID), .I_SELECT_OR_ADDRESS_PIN(cs_n),
    .I_SELECT_OR_ADDRESS_LEVEL(level), .I_NVM_ADDR_UPPER(port_pkg::NVM_ADDR_UPPER_DEFAULT),
    .I_FOUR_WIRE_SELECT(four_wire), .I_SCK(sck), .I_SDIO(sdio_wire), .O_SDIO(sdio_out),
    .O_SDIO_OE_N(sdio_oe_n), .O_SDO(sdo_out), .O_SDO_OE_N(sdo_oe_n), .O_SPI_MODE(spi_mode),
    .O_ROM_PROFILE(rom_profile), .O_I2C_ADDRESS(i2c_addr), .O_SYNC_HOLD(sync_hold),
    .O_RESET_CONTROL(reset_ctrl), .O_ELAPSED_TIME_TRIGGER(et_trig)
  );
  spi_host_model i_spi_host_model (.i_miso(miso), .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [15:0] d, input int n);
    i_spi_host_model.frame(port_pkg::DIR_WRITE, a, d, n, rd);
    repeat (8) @(posedge clk);
  endtask
  task automatic rdv(input logic [14:0] a, input int n, input logic [15:0] exp);
    i_spi_host_model.frame(port_pkg::DIR_READ, a, 16'h0000, n, rd);
    chk(rd, exp);
  endtask
  // Nine I2C bits: eight data bits and the acknowledge bit, as seen on the wire.
  task automatic i2c_byte(input logic [8:0] b, output logic [8:0] got);
    logic s;
    for (int i = 8; i >= 0; i--) begin
      i_spi_host_model.i2c_bit(b[i], s);
      got[i] = s;
    end
  endtask
  // A byte written by the host must be acknowledged by the port.
  task automatic i2c_w(input logic [7:0] b);
    logic [8:0] got;
    i2c_byte({b, 1'b1}, got);
    chk({7'h00, got}, {7'h00, b, 1'b0});
  endtask
  task automatic check_mode(input logic strap, input logic [6:0] addr);
    chk({15'h0000, spi_mode}, {15'h0000, strap});
    chk({9'h000, i2c_addr}, {9'h000, addr});
    chk({12'h000, rom_profile}, {12'h000, port_pkg::LVL_MID, port_pkg::LVL_HIGH});
  endtask
  task automatic startup(input logic strap, input logic [1:0] lvl, input logic [6:0] addr);
    @(posedge clk);
    power_down_n <= 1'b0;
    repeat (30) @(posedge clk);
    if_strap <= strap;
    level <= lvl;
    repeat (4) @(posedge clk);
    power_down_n <= 1'b1;
    repeat (12) @(posedge clk);
    check_mode(strap, addr);
  endtask
  task automatic final_report();
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    power_down_n = 1'b1;
    if_strap = 1'b1;
    level = port_pkg::LVL_MID;
    four_wire = 1'b0;
    err_count = 0;
    checks = 0;
    rd = 16'h0000;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (12) @(posedge clk);
    check_mode(1'b1, 7'h66);
    wr(port_pkg::SYNC_REG_ADDR, 16'h4000, 8);
    chk({15'h0000, sync_hold}, 16'h0001);
    rdv(port_pkg::SYNC_REG_ADDR, 8, 16'h0040);
    wr(port_pkg::SYNC_REG_ADDR, 16'h0000, 8);
    chk({15'h0000, sync_hold}, 16'h0000);
    wr(15'h0016, 16'h11a5, 16);
    chk({8'h00, reset_ctrl}, 16'h00a5);
    rdv(15'h0016, 16, 16'h11a5);
    wr(15'h0016, 16'h3cf0, 12);
    rdv(15'h0016, 16, 16'h3ca5);
    wr(15'h0100, 16'h7700, 8);
    rdv(15'h0100, 8, 16'h0000);
    @(posedge clk);
    four_wire <= 1'b1;
    rdv(port_pkg::RESET_CTRL_ADDR, 8, 16'h00a5);
    @(posedge clk);
    four_wire <= 1'b0;
    @(posedge clk);
    power_down_n <= 1'b0;
    repeat (8) @(posedge clk);
    wr(port_pkg::RESET_CTRL_ADDR, 16'h5a00, 8);
    chk({15'h0000, reset_ctrl === 8'h5a}, 16'h0000);
    startup(1'b0, port_pkg::LVL_LOW, 7'h64);
    wr(port_pkg::RESET_CTRL_ADDR, 16'h5a00, 8);
    chk({15'h0000, reset_ctrl === 8'h5a}, 16'h0000);
    i_spi_host_model.i2c_edge(1'b1);
    i2c_byte({8'hca, 1'b1}, ib);
    chk({7'h00, ib}, {7'h00, 8'hca, 1'b1});
    i_spi_host_model.i2c_edge(1'b0);
    i_spi_host_model.i2c_edge(1'b1);
    i2c_w(8'hc8);
    i2c_w(8'h00);
    i2c_w(8'h16);
    i2c_w(8'h33);
    i2c_w(8'hc3);
    i_spi_host_model.i2c_edge(1'b0);
    chk({8'h00, reset_ctrl}, 16'h00c3);
    i_spi_host_model.i2c_edge(1'b1);
    i2c_w(8'hc8);
    i2c_w(8'h00);
    i2c_w(8'h17);
    i_spi_host_model.i2c_edge(1'b1);
    i2c_w(8'hc9);
    i2c_byte(9'h1ff, ib);
    chk({7'h00, ib}, {7'h00, 8'hc3, 1'b1});
    i_spi_host_model.i2c_edge(1'b0);
    startup(1'b1, port_pkg::LVL_HIGH, 7'h65);
    wr(port_pkg::RESET_CTRL_ADDR, 16'h5a00, 8);
    chk({8'h00, reset_ctrl}, 16'h005a);
    rdv(15'h0016, 8, 16'h0033);
    wr(port_pkg::SYNC_REG_ADDR, 16'h0000, 16);
    chk({8'h00, reset_ctrl}, 16'h005a);
    final_report();
  end
endmodule
